// ==== logic/pin_mux_pkg.sv ====
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;  // byte address width on the register bus
  localparam int DATA_W = 32;  // bus data width
  localparam int REG_W  = 16;  // every register is 16 bits in the low lanes

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_EXT_BUS_SELECT     = 16'h1c00;
  localparam logic [15:0] IDX_CLOCK_GATING_ONE   = 16'h1c02;
  localparam logic [15:0] IDX_CLOCK_GATING_TWO   = 16'h1c03;
  localparam logic [15:0] IDX_OUTPUT_SLEW        = 16'h1c16;
  localparam logic [15:0] IDX_PULL_INHIBIT_ONE   = 16'h1c17;
  localparam logic [15:0] IDX_PULL_INHIBIT_TWO   = 16'h1c18;
  localparam logic [15:0] IDX_PULL_INHIBIT_THREE = 16'h1c19;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ROUTE_LSB        = 12;  // routing field of external_bus_select
  localparam int ROUTE_W          = 3;
  localparam int SLEW_MEM_IF_BIT  = 0;   // 1 = slow edges on memory interface pins
  localparam int SLEW_CLK_OUT_BIT = 1;   // 1 = slow edges on the clock output pin

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  ROUTE_RESET  = 3'h1;
  localparam logic [15:0] PULL_RESET   = 16'h0000;  // inhibit clear: pulls on
  localparam logic [15:0] SLEW_RESET   = 16'h0000;  // fast edges
  localparam logic [15:0] GATING_RESET = 16'h0000;  // every peripheral clock off

  // ----------------------------------------------------------------
  // routing field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_UNSUPPORTED = 3'h0;
  localparam logic [2:0] MODE_SPI_GPIO    = 3'h1;
  localparam logic [2:0] MODE_ALL_GPIO    = 3'h2;
  localparam logic [2:0] MODE_SPI_I2S3    = 3'h3;
  localparam logic [2:0] MODE_I2S2_UART   = 3'h4;
  localparam logic [2:0] MODE_SPI_UART    = 3'h5;
  localparam logic [2:0] MODE_I2S2_I2S3   = 3'h6;
  localparam logic [2:0] MODE_RESERVED    = 3'h7;

  // function carried by a group of four shared pins
  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_GPIO = 3'h1,
    FN_I2S2 = 3'h2,
    FN_I2S3 = 3'h3,
    FN_SPI  = 3'h4,
    FN_UART = 3'h5
  } pin_fn_e;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] regAddr(input logic [15:0] idx);
    return {idx[13:0], 2'h0};
  endfunction : regAddr

endpackage : pin_mux_pkg

// ==== logic/avalon_reg_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

module avalon_reg_slave
  import pin_mux_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              avsRead,
  input  wire logic              avsWrite,
  input  wire logic [REG_W-1:0]  rdValue,      // read value for the current address
  output var  logic              waitRequestQ,
  output var  logic [DATA_W-1:0] readDataQ,
  output logic                   commitWrite   // write takes effect this edge
);

  // ----------------------------------------------------------------
  // one-cycle answer: first edge drops waitrequest, second commits
  // ----------------------------------------------------------------
  // waitrequest idles high so a new request is never accepted blindly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitRequestQ <= 1'b1;
    end else if ((avsRead || avsWrite) && waitRequestQ) begin
      waitRequestQ <= 1'b0;
    end else begin
      waitRequestQ <= 1'b1;
    end
  end

  // read data latched together with the drop of waitrequest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readDataQ <= '0;
    end else if (avsRead && waitRequestQ) begin
      readDataQ <= {{(DATA_W-REG_W){1'b0}}, rdValue};
    end
  end

  // write lands only at the edge where the master sees waitrequest low
  assign commitWrite = avsWrite && !waitRequestQ;

endmodule : avalon_reg_slave

`default_nettype wire

// ==== logic/route_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module route_decoder
  import pin_mux_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [2:0]   routeMode,
  output var  pin_fn_e      lowSelQ,          // shared pins 8..11
  output var  pin_fn_e      highSelQ,         // shared pins 12..15
  output var  logic         dedSpiEnQ,        // dedicated serial pins in use
  output var  logic         dedGpioEnQ,       // dedicated gpio 12..17 in use
  output var  logic         routeSupportedQ
);

  // ----------------------------------------------------------------
  // mode table
  // ----------------------------------------------------------------
  // returns {low group, high group, dedicated enable, supported}
  function automatic logic [7:0] decode(input logic [2:0] m);
    unique case (m)
      MODE_SPI_GPIO:  decode = {FN_I2S2, FN_UART, 1'b1, 1'b1};  // [RQ6]
      MODE_ALL_GPIO:  decode = {FN_GPIO, FN_GPIO, 1'b0, 1'b1};  // [RQ7]
      MODE_SPI_I2S3:  decode = {FN_SPI,  FN_I2S3, 1'b0, 1'b1};  // [RQ8]
      MODE_I2S2_UART: decode = {FN_I2S2, FN_UART, 1'b0, 1'b1};  // [RQ9]
      MODE_SPI_UART:  decode = {FN_SPI,  FN_UART, 1'b0, 1'b1};  // [RQ9]
      MODE_I2S2_I2S3: decode = {FN_I2S2, FN_I2S3, 1'b1, 1'b1};  // [RQ10]
      MODE_RESERVED:  decode = {FN_NONE, FN_NONE, 1'b0, 1'b0};  // [RQ14]
      default:        decode = {FN_NONE, FN_NONE, 1'b0, 1'b0};  // [RQ11]
    endcase
  endfunction : decode

  logic [7:0] dec;  // decoded selection

  always_comb begin
    dec = decode(routeMode);
  end

  // registered so every pin group switches on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowSelQ         <= FN_NONE;
      highSelQ        <= FN_NONE;
      dedSpiEnQ       <= 1'b0;
      dedGpioEnQ      <= 1'b0;
      routeSupportedQ <= 1'b0;
    end else begin
      lowSelQ         <= pin_fn_e'(dec[7:5]);
      highSelQ        <= pin_fn_e'(dec[4:2]);
      dedSpiEnQ       <= dec[1];
      dedGpioEnQ      <= dec[1];
      routeSupportedQ <= dec[0];
    end
  end

endmodule : route_decoder

`default_nettype wire

// ==== logic/pin_mux_top.sv ====
// Notes on behaviour
// RQ1: each pull resistor individually inhibited by software
// RQ2: software drops pulls where board already pulls
// RQ3: slew register picks fast or slow edges
// RQ4: one select register controls all pin routing
// RQ5: software resets peripherals after routing changes
// RQ6: mode 001: dedicated serial, gpio, i2s2, uart
// RQ7: mode 010: shared pins are gpio only
// RQ8: mode 011: serial low, i2s3 high group
// RQ9: modes 100/101: uart high; i2s2 or serial low
// RQ10: mode 110: dedicated on, i2s2 and i2s3
// RQ11: mode 000 unsupported, routes nothing
// RQ12: third inhibit register drives port pulldowns
// RQ13: peripheral clocks off after reset
// RQ14: mode 111 reserved, routes nothing
`timescale 1ns/1ps
`default_nettype none

module pin_mux_top
  import pin_mux_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  // register bus
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [DATA_W-1:0] avs_readdata,
  output var  logic              avs_waitrequest,
  // peripheral drive toward shared pins 8..15
  input  wire logic [7:0]        gpioSharedOut,
  input  wire logic [7:0]        gpioSharedOeN,
  input  wire logic [3:0]        i2s2Out,
  input  wire logic [3:0]        i2s2OeN,
  input  wire logic [3:0]        i2s3Out,
  input  wire logic [3:0]        i2s3OeN,
  input  wire logic [3:0]        spiOut,
  input  wire logic [3:0]        spiOeN,
  input  wire logic [3:0]        uartOut,
  input  wire logic [3:0]        uartOeN,
  // shared pins 8..15
  input  wire logic [7:0]        sharedPinIn,
  output var  logic [7:0]        sharedPinOut,
  output var  logic [7:0]        sharedPinOeN,
  // pin levels returned to peripherals
  output var  logic [7:0]        gpioSharedIn,
  output var  logic [3:0]        i2s2In,
  output var  logic [3:0]        i2s3In,
  output var  logic [3:0]        spiIn,
  output var  logic [3:0]        uartIn,
  // routing status
  output var  logic              dedicatedSpiEn,
  output var  logic              dedicatedGpioEn,
  output var  logic              routeSupported,
  // pad controls
  output var  logic [15:0]       pullEnableOne,
  output var  logic [15:0]       pullEnableTwo,
  output var  logic [15:0]       pullEnableThree,
  output var  logic              slewSlowMemIf,
  output var  logic              slewSlowClkOut,
  output var  logic [15:0]       periphClkEnOne,
  output var  logic [15:0]       periphClkEnTwo
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [2:0]       routeModeQ;        // routing field of external_bus_select
  logic [15:0]      outputSlewQ;       // output_slew_control
  logic [15:0]      pullInhibitOneQ;   // pull_inhibit_one
  logic [15:0]      pullInhibitTwoQ;   // pull_inhibit_two
  logic [15:0]      pullInhibitThreeQ; // pull_inhibit_three
  logic [15:0]      clockGatingOneQ;   // clock_gating_one, 1 = clock runs
  logic [15:0]      clockGatingTwoQ;   // clock_gating_two
  logic             commitWrite;       // write lands this edge
  logic [REG_W-1:0] rdValue;           // read mux output
  pin_fn_e          lowSel;            // function on pins 8..11
  pin_fn_e          highSel;           // function on pins 12..15
  logic             dedSpiEn;
  logic             dedGpioEn;
  logic             supported;

  // merge write data into a register under the two low byte enables
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = old;
    if (be[0]) merge[7:0]  = wd[7:0];
    if (be[1]) merge[15:8] = wd[15:8];
  endfunction : merge

  // address match on one register index, used for reads and writes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == regAddr(idx);
  endfunction : hit

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  avalon_reg_slave u_slave (
    .clk          (clk),
    .rst_n        (rst_n),
    .avsRead      (avs_read),
    .avsWrite     (avs_write),
    .rdValue      (rdValue),
    .waitRequestQ (avs_waitrequest),
    .readDataQ    (avs_readdata),
    .commitWrite  (commitWrite)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    rdValue = '0;
    if (hit(avs_address, IDX_EXT_BUS_SELECT)) begin
      rdValue[ROUTE_LSB +: ROUTE_W] = routeModeQ;
    end else if (hit(avs_address, IDX_OUTPUT_SLEW)) begin
      rdValue = outputSlewQ;
    end else if (hit(avs_address, IDX_PULL_INHIBIT_ONE)) begin
      rdValue = pullInhibitOneQ;
    end else if (hit(avs_address, IDX_PULL_INHIBIT_TWO)) begin
      rdValue = pullInhibitTwoQ;
    end else if (hit(avs_address, IDX_PULL_INHIBIT_THREE)) begin
      rdValue = pullInhibitThreeQ;
    end else if (hit(avs_address, IDX_CLOCK_GATING_ONE)) begin
      rdValue = clockGatingOneQ;
    end else if (hit(avs_address, IDX_CLOCK_GATING_TWO)) begin
      rdValue = clockGatingTwoQ;
    end
  end

  // ----------------------------------------------------------------
  // routing select register
  // ----------------------------------------------------------------
  // the only place routing can change; other bits read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      routeModeQ <= ROUTE_RESET;
    end else if (commitWrite && hit(avs_address, IDX_EXT_BUS_SELECT) && avs_byteenable[1]) begin
      routeModeQ <= avs_writedata[ROUTE_LSB +: ROUTE_W];  // [RQ4]
    end
  end

  // ----------------------------------------------------------------
  // pad control registers
  // ----------------------------------------------------------------
  // slew register: only two bits steer pads, the rest is plain storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outputSlewQ <= SLEW_RESET;
    end else if (commitWrite && hit(avs_address, IDX_OUTPUT_SLEW)) begin
      outputSlewQ <= merge(outputSlewQ, avs_writedata, avs_byteenable);  // [RQ3]
    end
  end

  // three inhibit registers, one bit per pad pull
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullInhibitOneQ   <= PULL_RESET;
      pullInhibitTwoQ   <= PULL_RESET;
      pullInhibitThreeQ <= PULL_RESET;
    end else if (commitWrite) begin
      if (hit(avs_address, IDX_PULL_INHIBIT_ONE)) begin
        pullInhibitOneQ <= merge(pullInhibitOneQ, avs_writedata, avs_byteenable);  // [RQ1]
      end
      if (hit(avs_address, IDX_PULL_INHIBIT_TWO)) begin
        pullInhibitTwoQ <= merge(pullInhibitTwoQ, avs_writedata, avs_byteenable);  // [RQ1]
      end
      if (hit(avs_address, IDX_PULL_INHIBIT_THREE)) begin
        pullInhibitThreeQ <= merge(pullInhibitThreeQ, avs_writedata, avs_byteenable);  // [RQ12]
      end
    end
  end

  // clock gating: reset leaves every peripheral clock stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockGatingOneQ <= GATING_RESET;  // [RQ13]
      clockGatingTwoQ <= GATING_RESET;  // [RQ13]
    end else if (commitWrite) begin
      if (hit(avs_address, IDX_CLOCK_GATING_ONE)) begin
        clockGatingOneQ <= merge(clockGatingOneQ, avs_writedata, avs_byteenable);
      end
      if (hit(avs_address, IDX_CLOCK_GATING_TWO)) begin
        clockGatingTwoQ <= merge(clockGatingTwoQ, avs_writedata, avs_byteenable);
      end
    end
  end

  // pad outputs; the reset-test pulldown has no bit and stays on outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullEnableOne   <= ~PULL_RESET;
      pullEnableTwo   <= ~PULL_RESET;
      pullEnableThree <= ~PULL_RESET;
      slewSlowMemIf   <= SLEW_RESET[SLEW_MEM_IF_BIT];
      slewSlowClkOut  <= SLEW_RESET[SLEW_CLK_OUT_BIT];
      periphClkEnOne  <= GATING_RESET;
      periphClkEnTwo  <= GATING_RESET;
    end else begin
      pullEnableOne   <= ~pullInhibitOneQ;    // [RQ1]
      pullEnableTwo   <= ~pullInhibitTwoQ;    // [RQ1]
      pullEnableThree <= ~pullInhibitThreeQ;  // [RQ12]
      slewSlowMemIf   <= outputSlewQ[SLEW_MEM_IF_BIT];   // [RQ3]
      slewSlowClkOut  <= outputSlewQ[SLEW_CLK_OUT_BIT];  // [RQ3]
      periphClkEnOne  <= clockGatingOneQ;
      periphClkEnTwo  <= clockGatingTwoQ;
    end
  end

  // ----------------------------------------------------------------
  // routing decode
  // ----------------------------------------------------------------
  route_decoder u_decode (
    .clk             (clk),
    .rst_n           (rst_n),
    .routeMode       (routeModeQ),
    .lowSelQ         (lowSel),
    .highSelQ        (highSel),
    .dedSpiEnQ       (dedSpiEn),
    .dedGpioEnQ      (dedGpioEn),
    .routeSupportedQ (supported)
  );

  // ----------------------------------------------------------------
  // shared pin multiplexer
  // ----------------------------------------------------------------
  logic [7:0] pinSync1;  // first stage, read only by the second
  logic [7:0] pinSync2;
  logic [7:0] pinOutD;
  logic [7:0] pinOeND;
  logic [7:0] gpioInD;
  logic [3:0] i2s2InD;
  logic [3:0] i2s3InD;
  logic [3:0] spiInD;
  logic [3:0] uartInD;

  // pin inputs come from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1 <= '0;
      pinSync2 <= '0;
    end else begin
      pinSync1 <= sharedPinIn;
      pinSync2 <= pinSync1;
    end
  end

  // a pin with no owner is released, so a stale peripheral cannot fight the board
  always_comb begin
    pin_fn_e sel;
    int      j;
    sel     = FN_NONE;
    j       = 0;
    pinOutD = '0;
    pinOeND = '1;
    gpioInD = '0;
    i2s2InD = '0;
    i2s3InD = '0;
    spiInD  = '0;
    uartInD = '0;
    for (int p = 0; p < 8; p++) begin
      sel = (p < 4) ? lowSel : highSel;
      j   = p % 4;
      unique case (sel)
        FN_GPIO: begin  // [RQ7]
          pinOutD[p] = gpioSharedOut[p];
          pinOeND[p] = gpioSharedOeN[p];
          gpioInD[p] = pinSync2[p];
        end
        FN_I2S2: begin  // [RQ6]
          pinOutD[p] = i2s2Out[j];
          pinOeND[p] = i2s2OeN[j];
          i2s2InD[j] = pinSync2[p];
        end
        FN_I2S3: begin  // [RQ8]
          pinOutD[p] = i2s3Out[j];
          pinOeND[p] = i2s3OeN[j];
          i2s3InD[j] = pinSync2[p];
        end
        FN_SPI: begin  // [RQ8]
          pinOutD[p] = spiOut[j];
          pinOeND[p] = spiOeN[j];
          spiInD[j]  = pinSync2[p];
        end
        FN_UART: begin  // [RQ9]
          pinOutD[p] = uartOut[j];
          pinOeND[p] = uartOeN[j];
          uartInD[j] = pinSync2[p];
        end
        default: begin  // [RQ14]
          pinOutD[p] = 1'b0;
          pinOeND[p] = 1'b1;
        end
      endcase
    end
  end

  // every routed signal is re-timed so top outputs come from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sharedPinOut    <= '0;
      sharedPinOeN    <= '1;
      gpioSharedIn    <= '0;
      i2s2In          <= '0;
      i2s3In          <= '0;
      spiIn           <= '0;
      uartIn          <= '0;
      dedicatedSpiEn  <= 1'b0;
      dedicatedGpioEn <= 1'b0;
      routeSupported  <= 1'b0;
    end else begin
      sharedPinOut    <= pinOutD;
      sharedPinOeN    <= pinOeND;
      gpioSharedIn    <= gpioInD;
      i2s2In          <= i2s2InD;
      i2s3In          <= i2s3InD;
      spiIn           <= spiInD;
      uartIn          <= uartInD;
      dedicatedSpiEn  <= dedSpiEn;   // [RQ10]
      dedicatedGpioEn <= dedGpioEn;  // [RQ6]
      routeSupported  <= supported;  // [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // mode held long enough to reach the pins
  sequence modeHeld(logic [2:0] m);
    (routeModeQ == m) [*3];
  endsequence

  chk_route_single_point: assert property (  // [RQ4]
    $changed(routeModeQ) |-> $past(commitWrite) && $past(hit(avs_address, IDX_EXT_BUS_SELECT)))
    else $error("routing changed without a select register write");

  chk_reserved_mode_idle: assert property (  // [RQ14]
    modeHeld(MODE_RESERVED) |-> (sharedPinOeN == 8'hff) && !routeSupported)
    else $error("reserved mode drives shared pins");

  chk_zero_mode_idle: assert property (  // [RQ11]
    modeHeld(MODE_UNSUPPORTED) |-> (sharedPinOeN == 8'hff) && !dedicatedSpiEn)
    else $error("unsupported mode drives pins");

  chk_gpio_mode_pins: assert property (  // [RQ7]
    modeHeld(MODE_ALL_GPIO) |=> (sharedPinOut == $past(gpioSharedOut)) && !dedicatedGpioEn)
    else $error("gpio mode does not route gpio to shared pins");

  chk_spi_i2s3_pins: assert property (  // [RQ8]
    modeHeld(MODE_SPI_I2S3) |=> (sharedPinOut == {$past(i2s3Out), $past(spiOut)}))
    else $error("mode three routing wrong");

  chk_uart_high_pins: assert property (  // [RQ9]
    modeHeld(MODE_SPI_UART) |=> (sharedPinOeN[7:4] == $past(uartOeN)) && !dedicatedSpiEn)
    else $error("uart not on upper shared pins");

  chk_dedicated_enable: assert property (  // [RQ10]
    modeHeld(MODE_I2S2_I2S3) |-> dedicatedSpiEn && dedicatedGpioEn && routeSupported)
    else $error("dedicated pins not enabled in mode six");

  chk_i2s2_low_pins: assert property (  // [RQ6]
    modeHeld(MODE_SPI_GPIO) |=> (sharedPinOut[3:0] == $past(i2s2Out)) && dedicatedGpioEn)
    else $error("mode one low group not i2s2");

  chk_slew_follow: assert property (  // [RQ3]
    commitWrite && hit(avs_address, IDX_OUTPUT_SLEW) && avs_byteenable[0]
      |-> ##2 slewSlowMemIf == $past(avs_writedata[SLEW_MEM_IF_BIT], 2))
    else $error("slew pad control did not follow write");

  chk_pull_three_map: assert property (  // [RQ12]
    commitWrite && hit(avs_address, IDX_PULL_INHIBIT_THREE) && (avs_byteenable[1:0] == 2'h3)
      |-> ##2 pullEnableThree == ~$past(avs_writedata[15:0], 2))
    else $error("third pull register not reflected on pads");

  chk_pull_one_map: assert property (  // [RQ1]
    commitWrite && hit(avs_address, IDX_PULL_INHIBIT_ONE) && (avs_byteenable[1:0] == 2'h3)
      |-> ##2 pullEnableOne == ~$past(avs_writedata[15:0], 2))
    else $error("first pull register not reflected on pads");

  chk_clock_off_idle: assert property (  // [RQ13]
    !(commitWrite && hit(avs_address, IDX_CLOCK_GATING_ONE)) [*3] |-> $stable(periphClkEnOne))
    else $error("peripheral clock enable moved without a write");

  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule : pin_mux_top

`default_nettype wire

// ==== sim/parallel_port_pin_mux_pull_slew_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module parallel_port_pin_mux_pull_slew_test
  import pin_mux_pkg::*;
();
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk, rst_n, avs_read, avs_write, avs_waitrequest, dSpi, dGpio, rSup, slewM, slewC;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [7:0]        gOut, gOeN, pinIn, pinOut, pinOeN, gIn;
  logic [3:0]        i2Out, i3Out, sOut, uOut, oeN4, i2In, i3In, sIn, uIn, be;
  logic [15:0]       pe1, pe2, pe3, ck1, ck2;
  int                err_total, total_checks;

  pin_mux_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpioSharedOut(gOut),
    .gpioSharedOeN(gOeN), .i2s2Out(i2Out), .i2s2OeN(oeN4), .i2s3Out(i3Out), .i2s3OeN(oeN4),
    .spiOut(sOut), .spiOeN(oeN4), .uartOut(uOut), .uartOeN(oeN4), .sharedPinIn(pinIn),
    .sharedPinOut(pinOut), .sharedPinOeN(pinOeN), .gpioSharedIn(gIn), .i2s2In(i2In), .i2s3In(i3In),
    .spiIn(sIn), .uartIn(uIn), .dedicatedSpiEn(dSpi), .dedicatedGpioEn(dGpio), .routeSupported(rSup),
    .pullEnableOne(pe1), .pullEnableTwo(pe2), .pullEnableThree(pe3), .slewSlowMemIf(slewM),
    .slewSlowClkOut(slewC), .periphClkEnOne(ck1), .periphClkEnTwo(ck2));

  // one bus cycle: held until waitrequest is seen low, bounded wait
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avs_address <= regAddr(idx);
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // expected pin drive per routing code: high group, low group
  function automatic logic [7:0] expPins(input logic [2:0] m);
    case (m)
      3'h1, 3'h4: return {uOut, i2Out};
      3'h2: return gOut;
      3'h3: return {i3Out, sOut};
      3'h5: return {uOut, sOut};
      3'h6: return {i3Out, i2Out};
      default: return 8'h00;
    endcase
  endfunction : expPins

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] m;
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {gOut, gOeN, oeN4, pinIn} = {8'ha5, 8'h00, 4'h0, 8'h3c};
    be = 4'hf;
    {i2Out, i3Out, sOut, uOut} = 16'h3c69;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pe1, 16'hffff);
    chk(pinOeN, 8'hff);
    acc(1'b0, IDX_CLOCK_GATING_ONE, 32'h0);
    chk(rd, 32'h0);
    chk({ck2, ck1}, 32'h0);
    // every routing code, reserved and unsupported ones included
    for (int k = 0; k < 8; k++) begin
      m = k[2:0];
      acc(1'b1, IDX_EXT_BUS_SELECT, {17'h0, m, 12'h0});
      acc(1'b0, IDX_EXT_BUS_SELECT, 32'h0);
      chk(rd, {17'h0, m, 12'h0});
      // peripherals would be restarted here after the routing change
      repeat (4) @(posedge clk);
      #1;
      chk(pinOut, expPins(m));
      chk(i2In, (m == 3'h1 || m == 3'h4 || m == 3'h6) ? 4'hc : 4'h0);
      chk(i3In, (m == 3'h3 || m == 3'h6) ? 4'h3 : 4'h0);
      chk(sIn, (m == 3'h3 || m == 3'h5) ? 4'hc : 4'h0);
      chk(pinOeN, (m == 3'h0 || m == 3'h7) ? 8'hff : 8'h00);
      chk({dSpi, dGpio}, (m == 3'h1 || m == 3'h6) ? 2'h3 : 2'h0);
      chk(rSup, m != 3'h0 && m != 3'h7);
      chk(uIn, (m == 3'h1 || m == 3'h4 || m == 3'h5) ? 4'h3 : 4'h0);
      chk(gIn, (m == 3'h2) ? 8'h3c : 8'h00);
    end
    acc(1'b1, IDX_PULL_INHIBIT_ONE, 32'h8001);
    acc(1'b1, IDX_PULL_INHIBIT_TWO, 32'h0ff0);
    acc(1'b1, IDX_PULL_INHIBIT_THREE, 32'h1234);
    acc(1'b1, IDX_OUTPUT_SLEW, 32'h0002);
    acc(1'b1, IDX_CLOCK_GATING_ONE, 32'ha5c3);
    acc(1'b1, 16'h1c20, 32'hffff);
    repeat (3) @(posedge clk);
    #1;
    chk({pe2, pe1}, 32'hf00f_7ffe);
    chk(pe3, 16'hedcb);
    chk({slewC, slewM}, 2'h2);
    chk(ck1, 16'ha5c3);
    acc(1'b0, IDX_PULL_INHIBIT_THREE, 32'h0);
    chk(rd, 32'h1234);
    acc(1'b0, 16'h1c20, 32'h0);
    chk(rd, 32'h0);
    // routing write without the upper byte lane must leave the field alone
    be <= 4'h1;
    acc(1'b1, IDX_EXT_BUS_SELECT, 32'h2000);
    be <= 4'hf;
    acc(1'b0, IDX_EXT_BUS_SELECT, 32'h0);
    chk(rd, 32'h7000);
    // mid-run reset stops every peripheral clock and restores the pulls
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({ck1, pe3}, 32'h0000_ffff);
    acc(1'b1, IDX_OUTPUT_SLEW, 32'h0001);
    repeat (3) @(posedge clk);
    #1;
    chk({slewC, slewM}, 2'h1);
    wrap_up();
  end
endmodule : parallel_port_pin_mux_pull_slew_test
`default_nettype wire
